/* File: sdt_timer.sv */
// Split dual 8-bit auto-reload timer with an APB register slave, sticky
// overflow flags and one level interrupt.
// Assumes an APB master on pclk and slow sources already free-running.
`timescale 1ns/1ps

module sdt_timer (
   input  wire logic        pclk,        // System clock, 100 MHz
   input  wire logic        presetn,     // Async reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB access phase
   input  wire logic        pwrite,      // APB direction, 1 = write
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error on unmapped address
   input  wire logic        ext_clk_in,  // External clock source
   input  wire logic        lfo_in,      // Low-frequency oscillator
   output logic             irq          // Level interrupt, active high
);

   typedef struct packed {
      sdt_pkg::sdt_ctrl_t ctrl;
      logic [1:0]         cksel;    // {high select, low select}
      logic [3:0]         ucksel;   // Upper timer clock select bits
      logic [7:0]         rlh;      // High reload value
      logic [7:0]         rll;      // Low reload value
      logic [7:0]         hi_cnt;   // High counter
      logic [7:0]         lo_cnt;   // Low counter
      logic [1:0]         status;   // Sticky overflow flags
      logic [1:0]         mask;     // Interrupt mask
      logic               ien;      // Timer interrupt enable
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
      logic               irq;
   } sdt_state_t;

   sdt_state_t          q;
   sdt_state_t          d;
   sdt_pkg::sdt_ticks_t ticks;
   logic                hsel;      // Effective high byte clock select
   logic                lsel;      // Effective low byte clock select
   logic                hi_tick;   // High counter count enable
   logic                lo_tick;   // Low counter count enable
   logic                acc;       // APB access completes this edge
   logic                wr;        // Completing write
   logic                wr_cnt;    // Completing write to the counters
   logic [1:0]          ovf_set;   // Overflow events this cycle
   logic [1:0]          w1c;       // Flags cleared by software this cycle

   // Slow clock sources
   sdt_clk_src u_src (
      .pclk       (pclk),
      .presetn    (presetn),
      .ext_clk_in (ext_clk_in),
      .lfo_in     (lfo_in),
      .ticks      (ticks)
   );

   // Count enable for one byte from its select bit and the external field
   function automatic logic tick_pick(input logic msel, input logic [1:0] xsel,
                                      input sdt_pkg::sdt_ticks_t t);
      logic r;
      r = 1'b0;
      if (msel) begin
         r = 1'b1;
      end else begin
         case (xsel)
            sdt_pkg::XSEL_DIV12: r = t.div12;
            sdt_pkg::XSEL_EXT8:  r = t.ext8;
            sdt_pkg::XSEL_LFO:   r = t.low_frequency_oscillator;
            default:             r = 1'b0;           // Reserved code counts nothing
         endcase
      end
      return r;
   endfunction : tick_pick

   // Address decode: true for every mapped offset
   function automatic logic is_mapped(input logic [7:0] a);
      logic m;
      m = 1'b0;
      if (a == sdt_pkg::OFF_CTRL) m = 1'b1;
      else if (a == sdt_pkg::OFF_CKSEL) m = 1'b1;
      else if (a == sdt_pkg::OFF_UCKSEL) m = 1'b1;
      else if (a == sdt_pkg::OFF_RELOAD) m = 1'b1;
      else if (a == sdt_pkg::OFF_STATUS) m = 1'b1;
      else if (a == sdt_pkg::OFF_MASK) m = 1'b1;
      else if (a == sdt_pkg::OFF_IEN) m = 1'b1;
      else if (a == sdt_pkg::OFF_COUNT) m = 1'b1;
      return m;
   endfunction : is_mapped

   // Read mux; unused bits and unmapped offsets read as zero
   function automatic logic [31:0] rd_mux(input logic [7:0] a, input sdt_state_t s);
      logic [31:0] v;
      v = sdt_pkg::RST_WORD;
      if (a == sdt_pkg::OFF_CTRL) begin
         v[sdt_pkg::CTRL_FLD_HI:0] = s.ctrl;
         v[sdt_pkg::CTRL_HF] = s.status[sdt_pkg::ST_HI];
         v[sdt_pkg::CTRL_LF] = s.status[sdt_pkg::ST_LO];
      end else if (a == sdt_pkg::OFF_CKSEL) begin
         v[sdt_pkg::CKSEL_HI:sdt_pkg::CKSEL_LO] = s.cksel;
      end else if (a == sdt_pkg::OFF_UCKSEL) begin
         v[sdt_pkg::UCK_FLD_HI:0] = s.ucksel;
      end else if (a == sdt_pkg::OFF_RELOAD) begin
         v[15:0] = {s.rlh, s.rll};
      end else if (a == sdt_pkg::OFF_STATUS) begin
         v[1:0] = s.status;
      end else if (a == sdt_pkg::OFF_MASK) begin
         v[1:0] = s.mask;
      end else if (a == sdt_pkg::OFF_IEN) begin
         v[0] = s.ien;
      end else if (a == sdt_pkg::OFF_COUNT) begin
         v[15:0] = {s.hi_cnt, s.lo_cnt};
      end
      return v;
   endfunction : rd_mux

   // Clock selection for both bytes, from either select register
   always_comb begin
      hsel = q.ctrl.usel ? q.ucksel[sdt_pkg::UCK_HI] : q.cksel[1];
      lsel = q.ctrl.usel ? q.ucksel[sdt_pkg::UCK_LO] : q.cksel[0];
      hi_tick = tick_pick(hsel, q.ctrl.xsel, ticks);
      lo_tick = tick_pick(lsel, q.ctrl.xsel, ticks);
      acc = psel && penable && q.pready;
      wr = acc && pwrite;
      wr_cnt = wr && (paddr == sdt_pkg::OFF_COUNT);
      w1c = (wr && (paddr == sdt_pkg::OFF_STATUS)) ? pwdata[1:0] : 2'h0;
   end

   // Next state: counters, flags, register writes and bus answer
   always_comb begin
      d = q;
      ovf_set = 2'h0;
      // Counting
      if (q.ctrl.split) begin
         // Low byte ignores the run bit
         if (lo_tick) begin
            if (q.lo_cnt == sdt_pkg::BYTE_MAX) begin
               d.lo_cnt = q.rll;
               ovf_set[sdt_pkg::ST_LO] = 1'b1;
            end else begin
               d.lo_cnt = q.lo_cnt + 8'h01;
            end
         end
         if (q.ctrl.run && hi_tick) begin
            if (q.hi_cnt == sdt_pkg::BYTE_MAX) begin
               d.hi_cnt = q.rlh;
               ovf_set[sdt_pkg::ST_HI] = 1'b1;
            end else begin
               d.hi_cnt = q.hi_cnt + 8'h01;
            end
         end
      end else if (q.ctrl.run && lo_tick) begin
         // Whole 16-bit timer on the low byte clock
         if ({q.hi_cnt, q.lo_cnt} == sdt_pkg::WORD_MAX) begin
            {d.hi_cnt, d.lo_cnt} = {q.rlh, q.rll};
            ovf_set[sdt_pkg::ST_HI] = 1'b1;
         end else begin
            {d.hi_cnt, d.lo_cnt} = 16'({q.hi_cnt, q.lo_cnt} + 16'h0001);
         end
      end
      // Register writes; a counter write replaces any count this cycle
      if (wr) begin
         if (paddr == sdt_pkg::OFF_CTRL) begin
            d.ctrl = pwdata[sdt_pkg::CTRL_FLD_HI:0];
         end else if (paddr == sdt_pkg::OFF_CKSEL) begin
            d.cksel = pwdata[sdt_pkg::CKSEL_HI:sdt_pkg::CKSEL_LO];
         end else if (paddr == sdt_pkg::OFF_UCKSEL) begin
            d.ucksel = pwdata[sdt_pkg::UCK_FLD_HI:0];
         end else if (paddr == sdt_pkg::OFF_RELOAD) begin
            {d.rlh, d.rll} = pwdata[15:0];
         end else if (paddr == sdt_pkg::OFF_MASK) begin
            d.mask = pwdata[1:0];
         end else if (paddr == sdt_pkg::OFF_IEN) begin
            d.ien = pwdata[0];
         end else if (paddr == sdt_pkg::OFF_COUNT) begin
            {d.hi_cnt, d.lo_cnt} = pwdata[15:0];
            ovf_set = 2'h0;
         end
      end
      // Sticky flags: only software clears, a new event wins
      d.status = (q.status & ~w1c) | ovf_set;
      // Interrupt level from the flags
      d.irq = q.ien && ((q.status[sdt_pkg::ST_HI] && q.mask[sdt_pkg::ST_HI]) ||
                        (q.status[sdt_pkg::ST_LO] && q.mask[sdt_pkg::ST_LO] &&
                         q.ctrl.lfie));
      // APB answer: ready in the first access cycle, data caught at setup
      d.pready = psel && !penable && !q.pready;
      if (psel && !penable) begin
         d.prdata = rd_mux(paddr, q);
         d.pslverr = !is_mapped(paddr);
      end else if (acc) begin
         d.pslverr = 1'b0;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign irq     = q.irq;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_div12_gap;
      (!ticks.div12)[*8] ##1 !ticks.div12 ##1 !ticks.div12 ##1 !ticks.div12 ##1
      ticks.div12;
   endsequence

   sequence s_hi_wrap;
      q.ctrl.split && q.ctrl.run && hi_tick && (q.hi_cnt == sdt_pkg::BYTE_MAX) && !wr_cnt;
   endsequence

   sequence s_lo_wrap;
      q.ctrl.split && lo_tick && (q.lo_cnt == sdt_pkg::BYTE_MAX) && !wr_cnt;
   endsequence

   AST_HIGH_GATED: assert property (
      (q.ctrl.split && !q.ctrl.run && !wr_cnt) |=> (q.hi_cnt == $past(q.hi_cnt)))
      else $error("high counter moved while stopped");

   AST_LOW_FREE: assert property (
      (q.ctrl.split && !q.ctrl.run && lo_tick && (q.lo_cnt != sdt_pkg::BYTE_MAX) && !wr_cnt)
      |=> (q.lo_cnt == 8'($past(q.lo_cnt) + 8'h01)))
      else $error("low counter did not count with run clear");

   AST_HIGH_RELOAD: assert property (
      s_hi_wrap |=> (q.hi_cnt == $past(q.rlh)) && q.status[sdt_pkg::ST_HI])
      else $error("high wrap did not reload and flag");

   AST_LOW_RELOAD: assert property (
      s_lo_wrap |=> (q.lo_cnt == $past(q.rll)) && q.status[sdt_pkg::ST_LO])
      else $error("low wrap did not reload and flag");

   AST_FLAG_STICKY: assert property (
      (q.status[sdt_pkg::ST_HI] && !w1c[sdt_pkg::ST_HI]) |=> q.status[sdt_pkg::ST_HI])
      else $error("high flag cleared without software");

   AST_IRQ_HIGH: assert property (
      (q.ien && q.status[sdt_pkg::ST_HI] && q.mask[sdt_pkg::ST_HI]) |=> irq)
      else $error("no interrupt for high overflow");

   AST_IRQ_LOW: assert property (
      (q.ien && q.ctrl.lfie && q.status[sdt_pkg::ST_LO] && q.mask[sdt_pkg::ST_LO]) |=> irq)
      else $error("no interrupt for low overflow");

   AST_IRQ_LOW_GATED: assert property (
      (!q.ctrl.lfie && !q.status[sdt_pkg::ST_HI]) |=> !irq)
      else $error("low overflow interrupted without low flag enable");

   AST_SYSTEM_CLOCK_HIGH: assert property (
      (q.ctrl.split && q.ctrl.run && hsel && (q.hi_cnt != sdt_pkg::BYTE_MAX) && !wr_cnt)
      |=> (q.hi_cnt == 8'($past(q.hi_cnt) + 8'h01)))
      else $error("high counter missed a system clock count");

   AST_RESERVED: assert property (
      (q.ctrl.split && !lsel && (q.ctrl.xsel == sdt_pkg::XSEL_RSVD) && !wr_cnt)
      |=> $stable(q.lo_cnt))
      else $error("reserved source produced counts");

   AST_DIV12: assert property (
      ticks.div12 |=> s_div12_gap)
      else $error("divide by twelve enable spacing wrong");

   // Slow enables last exactly one system clock
   AST_EXT8_PULSE: assert property (
      ticks.ext8 |=> !ticks.ext8)
      else $error("external enable longer than one cycle");

   AST_LFO_PULSE: assert property (
      ticks.low_frequency_oscillator |=> !ticks.low_frequency_oscillator)
      else $error("oscillator enable longer than one cycle");

   // Low byte on the system clock in split mode counts every cycle, run bit or not
   AST_SYSTEM_CLOCK_LOW: assert property (
      (q.ctrl.split && lsel && (q.lo_cnt != sdt_pkg::BYTE_MAX) && !wr_cnt)
      |=> (q.lo_cnt == 8'($past(q.lo_cnt) + 8'h01)))
      else $error("low counter missed a system clock count");

   // High byte on the divided clock only moves on its enable
   AST_HIGH_DIV12: assert property (
      (q.ctrl.split && !hsel && (q.ctrl.xsel == sdt_pkg::XSEL_DIV12) &&
       !ticks.div12 && !wr_cnt)
      |=> $stable(q.hi_cnt))
      else $error("high counter moved without a divided clock enable");

   AST_FLAG_STICKY_LOW: assert property (
      (q.status[sdt_pkg::ST_LO] && !w1c[sdt_pkg::ST_LO]) |=> q.status[sdt_pkg::ST_LO])
      else $error("low flag cleared without software");

   AST_IRQ_OFF: assert property (
      !q.ien |=> !irq)
      else $error("interrupt raised with timer interrupt disabled");

   // Whole 16-bit timer wraps on the low byte clock
   sequence s_word_wrap;
      !q.ctrl.split && q.ctrl.run && lo_tick &&
      ({q.hi_cnt, q.lo_cnt} == sdt_pkg::WORD_MAX) && !wr_cnt;
   endsequence

   AST_WORD_RELOAD: assert property (
      s_word_wrap |=> ({q.hi_cnt, q.lo_cnt} == {$past(q.rlh), $past(q.rll)}) &&
                      q.status[sdt_pkg::ST_HI])
      else $error("whole timer wrap did not reload and flag");

   AST_WORD_COUNT: assert property (
      (!q.ctrl.split && q.ctrl.run && lsel && ({q.hi_cnt, q.lo_cnt} != sdt_pkg::WORD_MAX) &&
       !wr_cnt)
      |=> ({q.hi_cnt, q.lo_cnt} == 16'({$past(q.hi_cnt), $past(q.lo_cnt)} + 16'h0001)))
      else $error("whole timer missed a count");

   AST_WORD_GATED: assert property (
      (!q.ctrl.split && !q.ctrl.run && !wr_cnt) |=> $stable(q.hi_cnt) && $stable(q.lo_cnt))
      else $error("whole timer moved while stopped");

   AST_WORD_NO_LOW: assert property (
      (!q.ctrl.split && !q.status[sdt_pkg::ST_LO]) |=> !q.status[sdt_pkg::ST_LO])
      else $error("low flag set while not split");

endmodule : sdt_timer

/* File: sdt_pkg.sv */
// Package for the split dual 8-bit reload timer: register map, field
// positions, clock source codes, reset values and shared carrier types.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package sdt_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;  // Timer control register
   localparam logic [7:0] OFF_CKSEL  = 8'h04;  // Clock select register
   localparam logic [7:0] OFF_UCKSEL = 8'h08;  // Upper timer clock select
   localparam logic [7:0] OFF_RELOAD = 8'h0C;  // High and low reload values
   localparam logic [7:0] OFF_STATUS = 8'h10;  // Sticky overflow flags, W1C
   localparam logic [7:0] OFF_MASK   = 8'h14;  // Interrupt mask, same layout
   localparam logic [7:0] OFF_IEN    = 8'h18;  // Timer interrupt enable
   localparam logic [7:0] OFF_COUNT  = 8'h1C;  // High and low counters

   // Control register fields
   localparam int unsigned CTRL_HF     = 7;    // High overflow flag, read only
   localparam int unsigned CTRL_LF     = 6;    // Low overflow flag, read only
   localparam int unsigned CTRL_FLD_HI = 5;    // Top of writable control field
   // Clock select register fields
   localparam int unsigned CKSEL_HI    = 5;    // High byte clock select
   localparam int unsigned CKSEL_LO    = 4;    // Low byte clock select
   // Upper timer clock select fields
   localparam int unsigned UCK_HI      = 1;    // Fourth timer high select
   localparam int unsigned UCK_LO      = 0;    // Fourth timer low select
   localparam int unsigned UCK_FLD_HI  = 3;    // Top of writable upper field
   // Status and mask fields
   localparam int unsigned ST_HI       = 0;    // High counter overflow
   localparam int unsigned ST_LO       = 1;    // Low counter overflow

   // External select field codes
   localparam logic [1:0] XSEL_DIV12 = 2'h0;   // System clock / 12
   localparam logic [1:0] XSEL_EXT8  = 2'h1;   // External clock / 8
   localparam logic [1:0] XSEL_RSVD  = 2'h2;   // Reserved, no clock
   localparam logic [1:0] XSEL_LFO   = 2'h3;   // Low-frequency oscillator

   // Divider terminal counts
   localparam logic [3:0] DIV12_LAST = 4'hB;   // Twelve system clocks
   localparam logic [2:0] EXT8_LAST  = 3'h7;   // Eight external edges

   // Counter limits and reset values
   localparam logic [7:0]  BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Single-cycle count enables from the slow sources
   typedef struct packed {
      logic div12;   // System clock divided by 12
      logic ext8;    // External clock divided by 8
      logic low_frequency_oscillator;     // Oscillator rising edge
   } sdt_ticks_t;

   // Writable control field, laid out as control bits 5:0
   typedef struct packed {
      logic       lfie;   // Low flag interrupt enable
      logic       usel;   // Take clock selects from the upper register
      logic       split;  // Split mode enable
      logic       run;    // Run control
      logic [1:0] xsel;   // External select field
   } sdt_ctrl_t;

endpackage : sdt_pkg

/* File: sdt_clk_src.sv */
// Slow clock sources for the split timer: system clock / 12 divider,
// synchronised external clock / 8 and synchronised oscillator edges.
// Assumes ext_clk_in and lfo_in are free-running and slower than pclk / 2.
`timescale 1ns/1ps

module sdt_clk_src (
   input  wire logic              pclk,        // System clock
   input  wire logic              presetn,     // Async reset, active low
   input  wire logic              ext_clk_in,  // External clock source
   input  wire logic              lfo_in,      // Low-frequency oscillator
   output sdt_pkg::sdt_ticks_t    ticks        // One-cycle count enables
);

   typedef struct packed {
      logic [2:0]          ext_s;    // Sync stages 1, 2 and edge history
      logic [2:0]          lfo_s;    // Sync stages 1, 2 and edge history
      logic [3:0]          div_cnt;  // System clock prescaler
      logic [2:0]          ext_cnt;  // External edge counter
      sdt_pkg::sdt_ticks_t ticks;
   } sdt_src_t;

   sdt_src_t q;
   sdt_src_t d;

   // Next state: stage 1 feeds only stage 2; edges are seen on stages 2 and 3
   always_comb begin
      d = q;
      d.ext_s = {q.ext_s[1:0], ext_clk_in};
      d.lfo_s = {q.lfo_s[1:0], lfo_in};
      d.ticks = '0;
      if (q.div_cnt == sdt_pkg::DIV12_LAST) begin
         d.div_cnt = '0;
         d.ticks.div12 = 1'b1;
      end else begin
         d.div_cnt = q.div_cnt + 4'h1;
      end
      // External clock divided by 8 as a single-cycle enable
      if (q.ext_s[1] && !q.ext_s[2]) begin
         d.ext_cnt = q.ext_cnt + 3'h1;
         d.ticks.ext8 = (q.ext_cnt == sdt_pkg::EXT8_LAST);
      end
      // Oscillator edge as a single-cycle enable
      d.ticks.low_frequency_oscillator = q.lfo_s[1] && !q.lfo_s[2];
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ticks = q.ticks;

endmodule : sdt_clk_src

/* File: sdt_timer_bench.sv */
// Self-checking bench for the split dual 8-bit reload timer: APB master tasks,
// free-running slow sources and random reload values.
// Assumes sdt_pkg and sdt_timer are compiled before this file.
`timescale 1ns/1ps

`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp); end end

module sdt_timer_bench;
   logic        pclk, presetn, psel, penable, pwrite, ext_clk_in, lfo_in;
   logic        pready, pslverr, irq, err;
   logic [7:0]  paddr, rh, rl;
   logic [31:0] pwdata, prdata, rd, seed;
   int          error_cnt, checked, phase;

   sdt_timer dut_u (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .ext_clk_in (ext_clk_in),
      .lfo_in     (lfo_in),
      .irq        (irq)
   );

   // System clock, 10 ns period
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Slow sources: external rising edge every 4 clocks, oscillator every 10
   always @(posedge pclk) begin
      phase <= (phase == 19) ? 0 : phase + 1;
      ext_clk_in <= phase[1];
      lfo_in <= (phase % 10) < 5;
   end

   // Pseudo-random step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Expected counts after n system clocks for each external select code
   function automatic logic [7:0] ticks(input logic [1:0] xsel, input int n);
      case (xsel)
         sdt_pkg::XSEL_DIV12: return 8'(n / 12);
         sdt_pkg::XSEL_EXT8:  return 8'(n / 32);
         sdt_pkg::XSEL_LFO:   return 8'(n / 10);
         default:             return 8'h00;
      endcase
   endfunction : ticks

   // True when got lies within tol of exp, modulo 256
   function automatic logic near(input logic [7:0] got, exp, tol);
      logic [7:0] d;
      d = got - exp;
      return (d <= tol) || ((8'h00 - d) <= tol);
   endfunction : near

   // Control word with split mode always on
   function automatic logic [31:0] ctl(input logic lfie, usel, run, input logic [1:0] xsel);
      sdt_pkg::sdt_ctrl_t c;
      c = '{lfie: lfie, usel: usel, split: 1'b1, run: run, xsel: xsel};
      return {26'h0, c};
   endfunction : ctl

   // One APB transfer; read data and error land in rd and err
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK(n, 1, "ready in first access cycle")
      `CHK(err, (a > sdt_pkg::OFF_COUNT), "error response")
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e, "read value")
   endtask : rchk

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      complete_run();
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      seed = 32'h2DA8BA9C;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, unmapped access, read-only and unused bits
      for (int i = 0; i < 8; i++) rchk(8'(i * 4), sdt_pkg::RST_WORD);
      rchk(8'h20, 32'h0);
      `CHK(err, 1'b1, "unmapped read")
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      `CHK(err, 1'b1, "unmapped write")
      apb(1'b1, sdt_pkg::OFF_UCKSEL, 32'hFFFF_FFFF);
      rchk(sdt_pkg::OFF_UCKSEL, 32'h0000_000F);
      apb(1'b1, sdt_pkg::OFF_UCKSEL, 32'h0);
      apb(1'b1, sdt_pkg::OFF_CTRL, 32'h0000_00C0);
      rchk(sdt_pkg::OFF_CTRL, 32'h0);
      seed = xs(seed);
      rh = 8'h40 | {2'b00, seed[5:0]};
      rl = 8'h40 | {2'b00, seed[13:8]};
      apb(1'b1, sdt_pkg::OFF_RELOAD, {seed[31:16], rh, rl});
      rchk(sdt_pkg::OFF_RELOAD, {16'h0, rh, rl});
      // Low byte wraps on the system clock while the run bit is clear
      apb(1'b1, sdt_pkg::OFF_CKSEL, 32'h10);
      apb(1'b1, sdt_pkg::OFF_COUNT, 32'h00FD);
      apb(1'b1, sdt_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0));
      idle(6);
      apb(1'b0, sdt_pkg::OFF_COUNT, 32'h0);
      `CHK(rd[15:8], 8'h00, "high byte ran")
      `CHK(near(rd[7:0], rl + 8'd6, 8'd6), 1'b1, "low reload")
      rchk(sdt_pkg::OFF_STATUS, 32'h2);
      rchk(sdt_pkg::OFF_CTRL, 32'h48);
      // High byte wrap, flag, interrupt and clear
      apb(1'b1, sdt_pkg::OFF_CKSEL, 32'h30);
      apb(1'b1, sdt_pkg::OFF_MASK, 32'h1);
      apb(1'b1, sdt_pkg::OFF_IEN, 32'h1);
      `CHK(irq, 1'b0, "low flag raised irq")
      apb(1'b1, sdt_pkg::OFF_COUNT, 32'hFE00);
      apb(1'b1, sdt_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 2'h0));
      idle(6);
      apb(1'b0, sdt_pkg::OFF_COUNT, 32'h0);
      `CHK(near(rd[15:8], rh + 8'd6, 8'd6), 1'b1, "high reload")
      rchk(sdt_pkg::OFF_STATUS, 32'h3);
      `CHK(irq, 1'b1, "no high irq")
      apb(1'b1, sdt_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0));
      idle(300);
      rchk(sdt_pkg::OFF_STATUS, 32'h3);
      apb(1'b1, sdt_pkg::OFF_STATUS, 32'h1);
      idle(2);
      `CHK(irq, 1'b0, "irq after clear")
      rchk(sdt_pkg::OFF_STATUS, 32'h2);
      apb(1'b1, sdt_pkg::OFF_MASK, 32'h3);
      idle(2);
      `CHK(irq, 1'b0, "low irq without enable")
      apb(1'b1, sdt_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h0));
      idle(2);
      `CHK(irq, 1'b1, "no low irq")
      apb(1'b1, sdt_pkg::OFF_IEN, 32'h0);
      idle(2);
      `CHK(irq, 1'b0, "irq while disabled")
      apb(1'b1, sdt_pkg::OFF_STATUS, 32'h3);
      apb(1'b1, sdt_pkg::OFF_CKSEL, 32'h0);
      // Every external select code on the low byte
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, sdt_pkg::OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'(k)));
         apb(1'b1, sdt_pkg::OFF_COUNT, 32'h0);
         idle(240);
         apb(1'b0, sdt_pkg::OFF_COUNT, 32'h0);
         `CHK(near(rd[7:0], ticks(2'(k), 242), (k == 2) ? 8'h00 : 8'h02), 1'b1, "rate")
         `CHK(rd[15:8], 8'h00, "high byte ran")
      end
      // Clock selects taken from the upper select register
      apb(1'b1, sdt_pkg::OFF_UCKSEL, 32'h3);
      apb(1'b1, sdt_pkg::OFF_CTRL, ctl(1'b0, 1'b1, 1'b1, sdt_pkg::XSEL_RSVD));
      apb(1'b1, sdt_pkg::OFF_COUNT, 32'h0);
      idle(20);
      apb(1'b0, sdt_pkg::OFF_COUNT, 32'h0);
      `CHK(near(rd[15:8], 8'd22, 8'd3), 1'b1, "upper high select")
      `CHK(near(rd[7:0], 8'd22, 8'd3), 1'b1, "upper low select")
      apb(1'b1, sdt_pkg::OFF_UCKSEL, 32'h0);
      apb(1'b1, sdt_pkg::OFF_COUNT, 32'h1234);
      idle(20);
      rchk(sdt_pkg::OFF_COUNT, 32'h1234);
      // Whole 16-bit timer on the low byte clock; a wrap sets only the high flag
      apb(1'b1, sdt_pkg::OFF_STATUS, 32'h3);
      apb(1'b1, sdt_pkg::OFF_CKSEL, 32'h10);
      apb(1'b1, sdt_pkg::OFF_COUNT, 32'hFFFD);
      apb(1'b1, sdt_pkg::OFF_CTRL, 32'h4);
      idle(6);
      apb(1'b0, sdt_pkg::OFF_COUNT, 32'h0);
      `CHK(rd[15:8], rh, "whole timer high reload")
      `CHK(near(rd[7:0], rl + 8'h04, 8'h02), 1'b1, "whole timer low reload")
      rchk(sdt_pkg::OFF_STATUS, 32'h1);
      complete_run();
   end
endmodule : sdt_timer_bench
